// ==== design/idle_wake_defines.vh ====
// Constants for the idle, wake and reset-status controller
`ifndef IDLE_WAKE_DEFINES_VH
`define IDLE_WAKE_DEFINES_VH

// Clock period and the two oscillator times, in ns
`define IW_CLK_NS      10
`define IW_SETTLE_NS   2000
`define IW_START_NS    200
// Least times round up to whole cycles
`define IW_SETTLE_CYC  ((`IW_SETTLE_NS + `IW_CLK_NS - 1) / `IW_CLK_NS)
`define IW_START_CYC   ((`IW_START_NS + `IW_CLK_NS - 1) / `IW_CLK_NS)
`define IW_CNT_W       16

// Power-management states
`define IW_ST_RESET    3'h0
`define IW_ST_RUN      3'h1
`define IW_ST_IDLE     3'h2
`define IW_ST_SLEEP    3'h3
`define IW_ST_WAKE     3'h4

// Program counter values
`define IW_PC_W        16
`define IW_PC_ZERO     16'h0000
`define IW_VEC_HIGH    16'h0008
`define IW_VEC_LOW     16'h0018
`define IW_PC_STEP     16'h0002

// Brown-out configuration that enables the software bit
`define IW_BOR_SW_CFG  2'h1

`endif

// ==== design/idle_wake_reset_status_control.v ====
// Idle mode, wake-up and reset-status controller
`include "idle_wake_defines.vh"

module idle_wake_reset_status_control #(
  parameter [15:0] SETTLE_CYC = `IW_SETTLE_CYC,
  parameter [15:0] START_CYC  = `IW_START_CYC,
  parameter        NUM_INT    = 8
) (
  // Clock and power-on reset
  input  wire                  clk_in,
  input  wire                  rst_in,
  // Pins and oscillator status from outside the clock domain
  input  wire                  external_reset_pin_n_in,
  input  wire                  primary_clk_ready_in,
  // Core events, one-cycle pulses
  input  wire                  sleep_instr_in,
  input  wire                  watchdog_clear_instr_in,
  input  wire                  reset_instr_in,
  input  wire                  brownout_in,
  input  wire                  wdt_timeout_in,
  input  wire                  clock_loss_in,
  input  wire                  stack_full_in,
  input  wire                  stack_underflow_in,
  // Software flag writes, one-cycle pulses
  input  wire                  stack_full_clr_in,
  input  wire                  stack_underflow_clr_in,
  input  wire                  poweron_flag_set_in,
  input  wire                  brownout_flag_set_in,
  input  wire                  soft_brownout_wr_in,
  input  wire                  soft_brownout_data_in,
  // Oscillator control write
  input  wire                  osc_ctrl_wr_in,
  input  wire                  idle_on_sleep_bit_in,
  input  wire [1:0]            clock_select_bits_in,
  input  wire [2:0]            internal_freq_select_in,
  input  wire                  internal_source_select_in,
  // Configuration
  input  wire                  stack_error_reset_enable_in,
  input  wire [1:0]            brownout_mode_config_in,
  input  wire                  two_speed_en_in,
  input  wire                  failsafe_en_in,
  input  wire                  wdt_en_in,
  // Interrupt sources
  input  wire [NUM_INT-1:0]    int_flags_in,
  input  wire [NUM_INT-1:0]    int_enables_in,
  input  wire                  int_high_prio_in,
  input  wire                  global_int_enable_in,
  input  wire                  low_priority_int_enable_in,
  // Program counter of the core
  input  wire [`IW_PC_W-1:0]   pc_in,
  // Clock gating and oscillator control
  output reg                   cpu_clk_en_out,
  output reg                   periph_clk_en_out,
  output reg                   cpu_reset_out,
  output reg                   sys_clk_internal_out,
  output reg                   primary_osc_en_out,
  output reg                   primary_ready_flag_out,
  output reg                   internal_osc_en_out,
  output reg                   internal_stable_flag_out,
  output reg                   low_freq_osc_en_out,
  output reg                   wdt_clear_out,
  output reg  [2:0]            pm_state_out,
  // Program counter load
  output reg                   pc_load_out,
  output reg  [`IW_PC_W-1:0]   pc_value_out,
  // Reset-cause and stack flags
  output reg                   reset_instr_flag_out,
  output reg                   timeout_flag_out,
  output reg                   power_down_flag_out,
  output reg                   poweron_flag_out,
  output reg                   brownout_flag_out,
  output reg                   stack_full_flag_out,
  output reg                   stack_underflow_flag_out,
  output reg                   soft_brownout_enable_out,
  // Oscillator control register
  output reg                   idle_on_sleep_bit_out,
  output reg  [1:0]            clock_select_bits_out,
  output reg  [2:0]            internal_freq_select_out,
  output reg                   internal_source_select_out
);

  // Synchronisers for the pin and the oscillator status
  reg                  ext_meta_r;     // First stage, read by second only
  reg                  ext_sync_r;     // Reset pin, active low
  reg                  prim_meta_r;
  reg                  prim_sync_r;    // Primary clock ready

  // State and working registers
  reg  [2:0]           state_r;
  reg  [2:0]           state_nxt;
  reg  [`IW_CNT_W-1:0] settle_cnt_r;   // Internal oscillator settling
  reg  [`IW_CNT_W-1:0] settle_cnt_nxt;
  reg  [`IW_CNT_W-1:0] start_cnt_r;    // CPU start delay
  reg  [`IW_CNT_W-1:0] start_cnt_nxt;
  reg                  two_spd_r;      // Running early on internal
  reg                  two_spd_nxt;
  reg                  prim_shut_r;    // Primary shut by early sleep
  reg                  prim_shut_nxt;
  reg  [`IW_PC_W-1:0]  wake_pc_r;      // Where the CPU resumes
  reg  [`IW_PC_W-1:0]  wake_pc_nxt;

  // Next values of registered outputs
  reg                  pc_load_nxt;
  reg  [`IW_PC_W-1:0]  pc_value_nxt;
  reg                  ri_nxt;
  reg                  to_nxt;
  reg                  pd_nxt;
  reg                  por_nxt;
  reg                  bor_nxt;
  reg                  sf_nxt;
  reg                  su_nxt;
  reg                  sbor_nxt;
  reg                  rst_evt;        // Any reset this cycle

  // Decoded conditions
  wire                 ext_low   = ~ext_sync_r;
  wire                 asleep    = (state_r == `IW_ST_IDLE) |
                                   (state_r == `IW_ST_SLEEP);
  wire                 int_wake  = |(int_flags_in & int_enables_in);
  wire                 int_on    = (internal_freq_select_out != 3'h0) |
                                   internal_source_select_out;
  wire                 early_ok  = two_speed_en_in | failsafe_en_in;
  wire                 src_int   = clock_select_bits_out[1] | two_spd_nxt |
                                   prim_shut_nxt;
  wire                 prim_en   = ~(clock_select_bits_out[1] |
                                     prim_shut_nxt);
  wire [`IW_PC_W-1:0]  pc_plus2  = pc_in + `IW_PC_STEP;
  wire                 int_branch = global_int_enable_in &
                         (int_high_prio_in | low_priority_int_enable_in);

  // Two-flop synchronisers; pin idles high, status idles not ready
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_meta_r  <= 1'b1;
      ext_sync_r  <= 1'b1;
      prim_meta_r <= 1'b0;
      prim_sync_r <= 1'b0;
    end else begin
      ext_meta_r  <= external_reset_pin_n_in;
      ext_sync_r  <= ext_meta_r;
      prim_meta_r <= primary_clk_ready_in;
      prim_sync_r <= prim_meta_r;
    end
  end

  // Next-state and flag logic
  always @* begin
    state_nxt      = state_r;
    start_cnt_nxt  = start_cnt_r;
    two_spd_nxt    = two_spd_r;
    prim_shut_nxt  = prim_shut_r;
    wake_pc_nxt    = wake_pc_r;
    pc_load_nxt    = 1'b0;
    pc_value_nxt   = pc_value_out;
    ri_nxt         = reset_instr_flag_out;
    to_nxt         = timeout_flag_out;
    pd_nxt         = power_down_flag_out;
    por_nxt        = poweron_flag_out | poweron_flag_set_in;
    bor_nxt        = brownout_flag_out | brownout_flag_set_in;
    // Software clears first, so a hardware set below wins
    sf_nxt         = stack_full_flag_out & ~stack_full_clr_in;
    su_nxt         = stack_underflow_flag_out & ~stack_underflow_clr_in;
    sbor_nxt       = soft_brownout_wr_in ? soft_brownout_data_in :
                     soft_brownout_enable_out;
    rst_evt        = 1'b0;

    // Settling counter restarts only when the output is disabled
    if (!int_on)
      settle_cnt_nxt = {`IW_CNT_W{1'b0}};
    else if (settle_cnt_r != SETTLE_CYC)
      settle_cnt_nxt = settle_cnt_r + 16'h0001;
    else
      settle_cnt_nxt = settle_cnt_r;

    case (state_r)
      `IW_ST_RESET: begin
        // Held while the pin is low; start early or wait for primary
        if (!ext_low && (early_ok || prim_sync_r)) begin
          state_nxt    = `IW_ST_RUN;
          two_spd_nxt  = early_ok & ~prim_sync_r;
          pc_load_nxt  = 1'b1;
          pc_value_nxt = `IW_PC_ZERO;
        end
      end
      `IW_ST_RUN: begin
        if (sleep_instr_in) begin
          // Idle bit picks idle; lower select bit plays no part
          state_nxt = idle_on_sleep_bit_out ?
                      `IW_ST_IDLE : `IW_ST_SLEEP;
          // Power-managed entry before primary ready shuts it down
          if (two_spd_r) begin
            prim_shut_nxt = 1'b1;
            two_spd_nxt   = 1'b0;
          end
        end
      end
      `IW_ST_IDLE, `IW_ST_SLEEP: begin
        // Only a reset, the watchdog or an enabled interrupt leaves here
        if (wdt_timeout_in) begin
          state_nxt   = `IW_ST_WAKE;
          to_nxt      = 1'b0;
          pd_nxt      = 1'b0;
          wake_pc_nxt = pc_plus2;
        end else if (int_wake) begin
          state_nxt   = `IW_ST_WAKE;
          pd_nxt      = 1'b0;
          if (!int_branch)
            wake_pc_nxt = pc_plus2;
          else if (int_high_prio_in)
            wake_pc_nxt = `IW_VEC_HIGH;
          else
            wake_pc_nxt = `IW_VEC_LOW;
        end
        start_cnt_nxt = {`IW_CNT_W{1'b0}};
      end
      `IW_ST_WAKE: begin
        // CPU runs on the first cycle after the fixed delay
        if (start_cnt_r >= START_CYC - 16'h0001) begin
          state_nxt    = `IW_ST_RUN;
          pc_load_nxt  = 1'b1;
          pc_value_nxt = wake_pc_r;
        end else begin
          start_cnt_nxt = start_cnt_r + 16'h0001;
        end
      end
      default: begin
        state_nxt = `IW_ST_RESET;
      end
    endcase

    // Primary comes up: leave the early internal clock
    if (two_spd_nxt && prim_sync_r)
      two_spd_nxt = 1'b0;

    // Reset sources, highest priority first
    if (ext_low) begin
      rst_evt = 1'b1;
      to_nxt  = 1'b1;
      if (asleep)
        pd_nxt = 1'b0;
    end else if (brownout_in) begin
      rst_evt = 1'b1;
      ri_nxt  = 1'b1;
      to_nxt  = 1'b1;
      pd_nxt  = 1'b1;
      bor_nxt = 1'b0;
    end else if (wdt_timeout_in &&
                 (state_r == `IW_ST_RUN)) begin
      rst_evt = 1'b1;
      to_nxt  = 1'b0;
    end else if (stack_full_in) begin
      sf_nxt  = 1'b1;
      rst_evt = stack_error_reset_enable_in;
    end else if (stack_underflow_in) begin
      su_nxt  = 1'b1;
      rst_evt = stack_error_reset_enable_in;
      // Without reset the core still vectors to zero
      if (!stack_error_reset_enable_in) begin
        pc_load_nxt  = 1'b1;
        pc_value_nxt = `IW_PC_ZERO;
      end
    end else if (reset_instr_in) begin
      rst_evt = 1'b1;
      ri_nxt  = 1'b0;
    end

    if (rst_evt) begin
      state_nxt     = `IW_ST_RESET;
      two_spd_nxt   = 1'b0;
      prim_shut_nxt = 1'b0;
      pc_load_nxt   = 1'b1;
      pc_value_nxt  = `IW_PC_ZERO;
      // Software bit survives only when configured and set
      if (brownout_mode_config_in != `IW_BOR_SW_CFG)
        sbor_nxt = 1'b0;
    end else if (osc_ctrl_wr_in) begin
      // Software choosing a source again lifts the early shutdown
      prim_shut_nxt = 1'b0;
    end
  end

  // Registered state, flags and outputs
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      // Power-on values
      state_r                    <= `IW_ST_RESET;
      settle_cnt_r               <= {`IW_CNT_W{1'b0}};
      start_cnt_r                <= {`IW_CNT_W{1'b0}};
      two_spd_r                  <= 1'b0;
      prim_shut_r                <= 1'b0;
      wake_pc_r                  <= `IW_PC_ZERO;
      cpu_clk_en_out             <= 1'b0;
      periph_clk_en_out          <= 1'b0;
      cpu_reset_out              <= 1'b1;
      sys_clk_internal_out       <= 1'b0;
      primary_osc_en_out         <= 1'b1;
      primary_ready_flag_out     <= 1'b0;
      internal_osc_en_out        <= 1'b0;
      internal_stable_flag_out   <= 1'b0;
      low_freq_osc_en_out        <= 1'b0;
      wdt_clear_out              <= 1'b0;
      pm_state_out               <= `IW_ST_RESET;
      pc_load_out                <= 1'b0;
      pc_value_out               <= `IW_PC_ZERO;
      reset_instr_flag_out       <= 1'b1;
      timeout_flag_out           <= 1'b1;
      power_down_flag_out        <= 1'b1;
      poweron_flag_out           <= 1'b0;
      brownout_flag_out          <= 1'b0;
      stack_full_flag_out        <= 1'b0;
      stack_underflow_flag_out   <= 1'b0;
      soft_brownout_enable_out   <= 1'b1;
      idle_on_sleep_bit_out      <= 1'b0;
      clock_select_bits_out      <= 2'h0;
      internal_freq_select_out   <= 3'h0;
      internal_source_select_out <= 1'b0;
    end else begin
      state_r                  <= state_nxt;
      settle_cnt_r             <= settle_cnt_nxt;
      start_cnt_r              <= start_cnt_nxt;
      two_spd_r                <= two_spd_nxt;
      prim_shut_r              <= prim_shut_nxt;
      wake_pc_r                <= wake_pc_nxt;
      // CPU clocked only in run; peripherals also in idle and wake
      cpu_clk_en_out           <= (state_nxt == `IW_ST_RUN);
      periph_clk_en_out        <= (state_nxt == `IW_ST_RUN) |
                                  (state_nxt == `IW_ST_IDLE) |
                                  (state_nxt == `IW_ST_WAKE);
      cpu_reset_out            <= (state_nxt == `IW_ST_RESET);
      sys_clk_internal_out     <= src_int;
      primary_osc_en_out       <= prim_en;
      primary_ready_flag_out   <= prim_en & prim_sync_r;
      internal_osc_en_out      <= int_on;
      internal_stable_flag_out <= int_on &
                                  (settle_cnt_nxt == SETTLE_CYC);
      low_freq_osc_en_out      <= wdt_en_in | failsafe_en_in;
      // Retuning counts only while the internal block clocks the system
      wdt_clear_out            <= sleep_instr_in | watchdog_clear_instr_in |
                                  (clock_loss_in & failsafe_en_in) |
                                  (osc_ctrl_wr_in & sys_clk_internal_out &
                                   (internal_freq_select_in !=
                                    internal_freq_select_out));
      pm_state_out             <= state_nxt;
      pc_load_out              <= pc_load_nxt;
      pc_value_out             <= pc_value_nxt;
      reset_instr_flag_out     <= ri_nxt;
      timeout_flag_out         <= to_nxt;
      power_down_flag_out      <= pd_nxt;
      poweron_flag_out         <= por_nxt;
      brownout_flag_out        <= bor_nxt;
      stack_full_flag_out      <= sf_nxt;
      stack_underflow_flag_out <= su_nxt;
      soft_brownout_enable_out <= sbor_nxt;
      // Written only by software; wake paths leave it alone
      if (osc_ctrl_wr_in) begin
        idle_on_sleep_bit_out      <= idle_on_sleep_bit_in;
        clock_select_bits_out      <= clock_select_bits_in;
        internal_freq_select_out   <= internal_freq_select_in;
        internal_source_select_out <= internal_source_select_in;
      end
    end
  end

endmodule

// ==== verif/primary_osc_model.sv ====
// Behavioural primary oscillator facing the controller
module primary_osc_model #(
  parameter int START = 8  // Start-up cycles, small for a short run
) (
  // Clock and enable from the controller
  input  wire logic clk_in,
  input  wire logic en_in,
  // Ready level back to the controller
  output logic      ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;  // Cycles since enable
  initial ready_out = 1'b0;
  // Ready only after a full start-up; drops at once when disabled,
  // so a controller that forgets the shutdown sees a stale clock
  always @(posedge clk_in) begin
    cnt <= en_in ? cnt + 1 : 0;
    ready_out <= en_in && cnt >= START;
  end
endmodule

// ==== verif/idle_wake_properties.sv ====
// Concurrent checks on the idle, wake and reset-status controller
module idle_wake_checker #(
  parameter [15:0] START_CYC = 16'h0002,
  parameter        NUM_INT   = 8
) (
  // Clock and reset
  input wire               clk_in,
  input wire               rst_in,
  // Watched inputs
  input wire               external_reset_pin_n_in,
  input wire               sleep_instr_in,
  input wire               brownout_in,
  input wire               wdt_timeout_in,
  input wire               failsafe_en_in,
  input wire               wdt_en_in,
  input wire [NUM_INT-1:0] int_flags_in,
  input wire [NUM_INT-1:0] int_enables_in,
  // Watched outputs
  input wire               cpu_clk_en_out,
  input wire               periph_clk_en_out,
  input wire               cpu_reset_out,
  input wire               primary_osc_en_out,
  input wire               primary_ready_flag_out,
  input wire               internal_osc_en_out,
  input wire               internal_stable_flag_out,
  input wire               low_freq_osc_en_out,
  input wire               wdt_clear_out,
  input wire [2:0]         pm_state_out,
  input wire               pc_load_out,
  input wire [15:0]        pc_value_out,
  input wire               timeout_flag_out,
  input wire               power_down_flag_out,
  input wire               idle_on_sleep_bit_out,
  input wire [1:0]         clock_select_bits_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0]  pin_hist_r;  // Recent pin samples; covers the sync lag
  logic [15:0] wake_len_r;  // Cycles spent in the wake state
  logic        pin_ok;      // No pin reset can be in flight
  assign pin_ok = external_reset_pin_n_in && (&pin_hist_r);
  // History and wake-length helpers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_hist_r <= '0;
      wake_len_r <= '0;
    end else begin
      pin_hist_r <= {pin_hist_r[1:0], external_reset_pin_n_in};
      wake_len_r <= (pm_state_out == 3'h4) ? wake_len_r + 16'h0001 : '0;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Quiet cycle: no pin or brown-out reset can preempt the event
  sequence s_quiet;
    pin_ok && !brownout_in;
  endsequence
  sequence s_wake_ends;
    pm_state_out == 3'h4 ##1 pm_state_out == 3'h1;
  endsequence
  chk_idle_entry: assert property (
    s_quiet ##0 pm_state_out == 3'h1 && sleep_instr_in && !wdt_timeout_in
    && idle_on_sleep_bit_out |=> pm_state_out == 3'h2 && !cpu_clk_en_out
    && periph_clk_en_out && wdt_clear_out) else $error("idle entry bad");
  chk_int_wake: assert property (
    s_quiet ##0 (pm_state_out == 3'h2 || pm_state_out == 3'h3)
    && (|(int_flags_in & int_enables_in)) |=> pm_state_out == 3'h4
    && !power_down_flag_out) else $error("interrupt wake bad");
  chk_wake_delay: assert property (
    s_wake_ends |-> wake_len_r == START_CYC && cpu_clk_en_out && pc_load_out)
    else $error("cpu start delay bad");
  chk_wake_keeps: assert property (
    pm_state_out == 3'h4 |-> !cpu_clk_en_out && $stable(clock_select_bits_out)
    && $stable(idle_on_sleep_bit_out)) else $error("wake changed control");
  chk_stable_en: assert property (
    internal_stable_flag_out |-> internal_osc_en_out)
    else $error("stable without oscillator");
  chk_settle_wait: assert property (
    $rose(internal_osc_en_out) |-> !internal_stable_flag_out [*2])
    else $error("stable before settling");
  chk_low_freq: assert property (
    (wdt_en_in || failsafe_en_in) [*2] |-> low_freq_osc_en_out)
    else $error("low frequency oscillator off");
  chk_wdt_reset: assert property (
    s_quiet ##0 pm_state_out == 3'h1 && wdt_timeout_in |=> cpu_reset_out
    && !timeout_flag_out && pc_load_out && pc_value_out == 16'h0000)
    else $error("watchdog reset bad");
  chk_primary_rdy: assert property (
    !primary_osc_en_out |-> !primary_ready_flag_out)
    else $error("ready while primary off");
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the idle, wake and reset-status controller
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in, rst_in, external_reset_pin_n_in, primary_clk_ready_in;
  logic sleep_instr_in, watchdog_clear_instr_in, reset_instr_in, brownout_in;
  logic wdt_timeout_in, clock_loss_in, stack_full_in, stack_underflow_in;
  logic stack_full_clr_in, stack_underflow_clr_in, poweron_flag_set_in;
  logic brownout_flag_set_in, soft_brownout_wr_in, soft_brownout_data_in;
  logic osc_ctrl_wr_in, idle_on_sleep_bit_in, internal_source_select_in;
  logic [1:0] clock_select_bits_in, brownout_mode_config_in;
  logic [2:0] internal_freq_select_in, internal_freq_select_out, pm_state_out;
  logic stack_error_reset_enable_in, two_speed_en_in, failsafe_en_in;
  logic wdt_en_in, int_high_prio_in, global_int_enable_in;
  logic low_priority_int_enable_in, cpu_clk_en_out, periph_clk_en_out;
  logic [7:0] int_flags_in, int_enables_in;
  logic [15:0] pc_in, pc_value_out;
  logic [1:0] clock_select_bits_out;
  logic cpu_reset_out, sys_clk_internal_out, primary_osc_en_out;
  logic primary_ready_flag_out, internal_osc_en_out, internal_stable_flag_out;
  logic low_freq_osc_en_out, wdt_clear_out, pc_load_out, reset_instr_flag_out;
  logic timeout_flag_out, power_down_flag_out, poweron_flag_out;
  logic brownout_flag_out, stack_full_flag_out, stack_underflow_flag_out;
  logic soft_brownout_enable_out, idle_on_sleep_bit_out;
  logic internal_source_select_out;
  int num_errors = 0, compares = 0, mf;  // mf models the eight status bits
  logic [15:0] pcq[$];  // Expected program-counter loads, in order
  logic [8:0] strb;  // Event strobes, one-hot
  assign {watchdog_clear_instr_in, soft_brownout_wr_in, osc_ctrl_wr_in,
    stack_underflow_in, stack_full_in, brownout_in, reset_instr_in,
    wdt_timeout_in, sleep_instr_in} = strb;
  wire [7:0] flags = {soft_brownout_enable_out, reset_instr_flag_out,
    timeout_flag_out, power_down_flag_out, poweron_flag_out,
    brownout_flag_out, stack_full_flag_out, stack_underflow_flag_out};
  idle_wake_reset_status_control #(.SETTLE_CYC(16'h0004),
    .START_CYC(16'h0002), .NUM_INT(8)) i_idle_wake_reset_status_control (.*);
  primary_osc_model #(.START(8)) i_primary_osc_model (.clk_in(clk_in),
    .en_in(primary_osc_en_out), .ready_out(primary_clk_ready_in));
  always #5 clk_in = ~clk_in;
  // Each load seen while an expectation is outstanding is matched against the oldest one
  always @(posedge clk_in)
    if (pc_load_out === 1'b1 && pcq.size() > 0)
      chk(pc_value_out, pcq.pop_front());
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // One-cycle event strobe, raised and dropped on falling edges
  task automatic pulse(input int k);
    @(negedge clk_in);
    strb = 9'h001 << k;
    @(negedge clk_in);
    strb = '0;
  endtask
  task automatic osc_wr(input logic i, input logic [1:0] c,
                        input logic [2:0] f, input logic s);
    {idle_on_sleep_bit_in, clock_select_bits_in} = {i, c};
    {internal_freq_select_in, internal_source_select_in} = {f, s};
    pulse(6);
  endtask
  // Bounded wait for a settled state, optionally with primary ready
  task automatic wait_pm(input logic [2:0] s, input logic need_rdy);
    int n = 0;
    while (!(pm_state_out === s && cpu_reset_out === 1'b0 &&
           (primary_ready_flag_out === 1'b1 || !need_rdy)) && n < 300) begin
      @(negedge clk_in);
      n++;
    end
    chk(n < 300, 1'b1);
  endtask
  // Soft enable survives a reset only in the software brown-out mode
  function automatic int keep_sb(input int f);
    if (brownout_mode_config_in == 2'h1 && f[7])
      return f;
    return f & ~32'h80;
  endfunction
  task automatic rst_ev(input int k);
    stack_error_reset_enable_in = (k == 4);
    if (k != 5)
      mf = keep_sb(mf);
    case (k)
      1: mf &= ~32'h20;
      2: mf &= ~32'h40;
      3: mf = (mf | 32'h70) & ~32'h04;
      4: mf |= 32'h02;
      5: mf |= 32'h01;
      default: mf |= 32'h20;
    endcase
    pcq.push_back(16'h0000);
    if (k == 9) begin
      external_reset_pin_n_in = 1'b0;  // Held low past the sync flops
      repeat (4) @(negedge clk_in);
      external_reset_pin_n_in = 1'b1;
    end else
      pulse(k);
    repeat (4) @(negedge clk_in);
    wait_pm(3'h1, 1'b1);
    chk(flags, mf[7:0]);
  endtask
  // Hang watchdog: far beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    close_out();
  end
  logic [3:0] gie = 4'hB, hp = 4'h5, lp = 4'h6;
  int rk[6] = '{2, 3, 4, 5, 1, 9};
  logic [15:0] ev;
  initial begin
    {clk_in, strb, clock_loss_in, stack_full_clr_in} = '0;
    {stack_underflow_clr_in, poweron_flag_set_in, brownout_flag_set_in} = '0;
    {soft_brownout_data_in, stack_error_reset_enable_in, failsafe_en_in} = '0;
    {wdt_en_in, int_high_prio_in, global_int_enable_in} = '0;
    {low_priority_int_enable_in, int_flags_in, int_enables_in} = '0;
    {idle_on_sleep_bit_in, clock_select_bits_in, brownout_mode_config_in} = '0;
    {internal_freq_select_in, internal_source_select_in, pc_in} = '0;
    {rst_in, external_reset_pin_n_in, two_speed_en_in} = 3'h7;
    void'($urandom(67));
    repeat (4) @(negedge clk_in);
    rst_in = 1'b0;
    mf = 32'hF0;
    wait_pm(3'h1, 1'b0);
    chk({primary_ready_flag_out, sys_clk_internal_out}, 2'h1);
    two_speed_en_in = 1'b0;
    wait_pm(3'h1, 1'b1);
    chk(flags, mf[7:0]);
    $display("test power-on done");
    for (int i = 0; i < 16; i++) begin
      osc_wr(1'b0, 2'h0, i[2:0], i[3]);
      @(negedge clk_in);
      chk(internal_osc_en_out, i != 0);
      repeat (6) @(negedge clk_in);
      chk(internal_stable_flag_out, i != 0);
    end
    pulse(8);
    chk(wdt_clear_out, 1'b1);
    $display("test oscillator done");
    osc_wr(1'b1, 2'h0, 3'h3, 1'b0);  // Idle bit first
    osc_wr(1'b1, 2'h2, 3'h3, 1'b0);  // Lower select cleared
    repeat (8) @(negedge clk_in);
    osc_wr(1'b1, 2'h2, 3'h5, 1'b0);
    chk(wdt_clear_out, 1'b1);
    repeat (8) @(negedge clk_in);
    for (int i = 0; i < 4; i++) begin
      pc_in = 16'($urandom);
      {global_int_enable_in, int_high_prio_in} = {gie[i], hp[i]};
      low_priority_int_enable_in = lp[i];
      ev = pc_in + 16'h0002;
      if (gie[i] && (hp[i] || lp[i]))
        ev = hp[i] ? 16'h0008 : 16'h0018;
      pulse(0);
      chk({pm_state_out, cpu_clk_en_out, periph_clk_en_out}, 5'h09);
      chk({primary_osc_en_out, primary_ready_flag_out}, 2'h0);
      int_flags_in = 8'h01 << ($urandom % 8);
      int_enables_in = ~int_flags_in;
      repeat (4) @(negedge clk_in);
      chk(pm_state_out, 3'h2);
      mf &= ~32'h10;
      pcq.push_back(ev);
      int_enables_in = int_flags_in;
      wait_pm(3'h1, 1'b0);
      chk(flags, mf[7:0]);
      chk(internal_stable_flag_out, 1'b1);
      chk({idle_on_sleep_bit_out, clock_select_bits_out,
           internal_freq_select_out, internal_source_select_out}, 7'h6A);
      {int_flags_in, int_enables_in} = '0;
    end
    $display("test idle wake done");
    osc_wr(1'b0, 2'h2, 3'h5, 1'b0);
    pc_in = 16'($urandom);
    pulse(0);
    chk(pm_state_out, 3'h3);
    mf &= ~32'h30;
    pcq.push_back(pc_in + 16'h0002);
    pulse(1);
    wait_pm(3'h1, 1'b0);
    chk(flags, mf[7:0]);
    $display("test sleep wake done");
    osc_wr(1'b0, 2'h0, 3'h5, 1'b0);
    wait_pm(3'h1, 1'b1);
    brownout_mode_config_in = 2'h1;
    soft_brownout_data_in = 1'b1;
    pulse(7);
    mf |= 32'h80;
    foreach (rk[j])
      rst_ev(rk[j]);
    brownout_mode_config_in = 2'h0;
    rst_ev(2);
    $display("test reset causes done");
    {wdt_en_in, failsafe_en_in} = 2'h1;
    repeat (3) @(negedge clk_in);
    chk(low_freq_osc_en_out, 1'b1);
    {wdt_en_in, failsafe_en_in} = 2'h2;
    repeat (3) @(negedge clk_in);
    chk(low_freq_osc_en_out, 1'b1);
    chk(pcq.size(), 16'h0000);
    $display("test low frequency done");
    close_out();
  end
endmodule
bind idle_wake_reset_status_control idle_wake_checker #(
  .START_CYC(START_CYC), .NUM_INT(NUM_INT)) i_idle_wake_checker (.*);
